/* File: common/radio_ctrl_pkg.sv */
// Shared constants, register map and types of the radio mode and timeout controller
package radio_ctrl_pkg;
  localparam int AW = 4;
  localparam int DW = 16;
  localparam int CW = 24;

  localparam logic [AW-1:0] ADDR_MODE     = 4'h0;
  localparam logic [AW-1:0] ADDR_PREAMBLE = 4'h1;
  localparam logic [AW-1:0] ADDR_CAL      = 4'h2;
  localparam logic [AW-1:0] ADDR_LVL_LIM  = 4'h3;
  localparam logic [AW-1:0] ADDR_PRE_LIM  = 4'h4;
  localparam logic [AW-1:0] ADDR_SYN_LIM  = 4'h5;
  localparam logic [AW-1:0] ADDR_RXCFG    = 4'h6;
  localparam logic [AW-1:0] ADDR_RAMP     = 4'h7;
  localparam logic [AW-1:0] ADDR_BW       = 4'h8;
  localparam logic [AW-1:0] ADDR_FLAGS    = 4'h9;
  localparam logic [AW-1:0] ADDR_TBIT     = 4'ha;
  localparam logic [AW-1:0] ADDR_CARRIER  = 4'hb;
  localparam logic [AW-1:0] ADDR_LVL_DLY  = 4'hc;
  localparam logic [AW-1:0] ADDR_LVL_THR  = 4'hd;

  // Mode register fields
  localparam int MODE_LSB = 0;
  localparam int FSK_BIT  = 3;
  localparam int OOK_BIT  = 4;
  // Preamble register fields
  localparam int TOL_LSB  = 0;
  localparam int LEN_LSB  = 5;
  localparam int DET_BIT  = 7;
  // Calibration register fields
  localparam int CAL_TRIG_BIT  = 0;
  localparam int CAL_BUSY_BIT  = 1;
  localparam int TEMP_DIS_BIT  = 2;
  localparam int AUTO_CAL_BIT  = 3;
  localparam int DELTA_LSB     = 4;
  localparam int TEMP_FLAG_BIT = 6;
  // Receive config fields
  localparam int TRIG_LSB = 0;
  localparam int AFC_BIT  = 3;
  // Bandwidth register fields
  localparam int RX_BANDWIDTH_LSB = 0;
  localparam int CBW_LSB  = 8;
  // Flag register bits
  localparam int FL_PRE    = 0;
  localparam int FL_TO_LSB = 1;
  localparam int FL_READY  = 4;
  localparam int FL_RXRDY  = 5;
  localparam int FL_LVLRDY = 6;
  localparam int NFLAGS    = 7;

  // Reset values
  localparam logic [2:0]    RST_MODE  = 3'h1;
  localparam logic [1:0]    RST_LEN   = 2'h1;
  localparam logic [4:0]    RST_TOL   = 5'h0a;
  localparam logic [DW-1:0] RST_TBIT  = 16'h0064;
  localparam logic [DW-1:0] RST_RAMP  = 16'h0028;
  localparam logic [DW-1:0] RST_LDLY  = 16'h0100;

  typedef enum logic [2:0] {
    MODE_SLEEP   = 3'b000,
    MODE_STANDBY = 3'b001,
    MODE_SYNTH_TX = 3'b010,
    MODE_TX      = 3'b011,
    MODE_SYNTH_RX = 3'b100,
    MODE_RX      = 3'b101
  } op_mode_t;

  typedef enum logic [1:0] {
    SQ_STEP  = 2'b00,
    SQ_WAIT  = 2'b01,
    SQ_READY = 2'b10
  } seq_state_t;

  localparam logic [2:0] TRIG_NONE  = 3'b000;
  localparam logic [2:0] TRIG_LVL   = 3'b001;
  localparam logic [2:0] TRIG_PRE   = 3'b110;
  localparam logic [2:0] TRIG_BOTH  = 3'b111;
  localparam logic [1:0] LEN_RSVD   = 2'b11;

  // Timing
  localparam int CLK_MHZ         = 40;
  localparam int CAL_TIME_MS     = 10;
  localparam int CAL_CYCLES_DEF  = CAL_TIME_MS * 1000 * CLK_MHZ;
  localparam int OSC_TIME_US     = 250;
  localparam int OSC_CYCLES_DEF  = OSC_TIME_US * CLK_MHZ;
  localparam int FS_TIME_US      = 60;
  localparam int FS_CYCLES_DEF   = FS_TIME_US * CLK_MHZ;
  localparam int TX_BASE_US      = 5;
  localparam int TX_BASE_CYC     = TX_BASE_US * CLK_MHZ;
  localparam int RAMP_CYC_PER_US = CLK_MHZ * 5 / 4;
  localparam int BITS_PER_UNIT   = 16;
  localparam int TEMP_STEP_C     = 5;
  localparam int N_BW            = 21;
  localparam int RX_SETTLE_US [N_BW] = '{2330, 1940, 1560, 1180, 984, 791, 601, 504, 407, 313,
                                         264, 215, 169, 144, 119, 97, 84, 71, 85, 74, 63};
endpackage

/* File: src/wait_timer.sv */
// One receive timeout: counts 16-bit units until its awaited flag or its limit
`timescale 1ns/1ps
module wait_timer
(
  input  wire logic       i_clock,
  input  wire logic       i_arst_n,
  input  wire logic       i_restart,
  input  wire logic       i_unit_tick,
  input  wire logic       i_enable,
  input  wire logic       i_seen,
  input  wire logic [7:0] i_limit,
  output logic            o_expire
);
  logic [7:0] units_q;
  logic       done_q;

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      units_q  <= 8'h00;
      done_q   <= 1'b1;
      o_expire <= 1'b0;
    end
    else
    begin
      o_expire <= 1'b0;
      if (i_restart)
      begin
        units_q <= 8'h00;
        done_q  <= 1'b0;
      end
      else if (!done_q && i_seen)
        done_q <= 1'b1;
      else if (!done_q && i_unit_tick && i_enable && i_limit != 8'h00)
      begin
        units_q <= units_q + 8'h01;
        if (units_q + 8'h01 == i_limit)
        begin
          o_expire <= 1'b1;
          done_q   <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: src/radio_ctrl.sv */
// Mode sequencing, calibration, preamble detection and receive timeouts of the radio
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
// How it works
// - Preamble length 1, 2, 3 bytes; 11 reserved
// - Detector enabled raises preamble flag per preamble
// - Calibrate once after power-on and manual reset
// - Trigger bit calibrates, only Standby in FSK
// - Temperature shift flag at selected threshold
// - Auto calibration starts on temperature shift
// - Calibration lasts about ten milliseconds
// - Level timeout after limit times 16 bits
// - Preamble timeout after limit times 16 bits
// - Sync timeout after limit times 16 bits
// - Trigger field selects which timeouts run
// - Mode field decodes the six modes
// - Mode change powers blocks in fixed order
// - Transmit settle: 5us, ramp (none in OOK), half bit
// - Receive settle from active bandwidth table
// - Receiver ready after settle time elapsed
// - First level sample after extra delay
// - Frequency correction subtracts offset per receive
module radio_ctrl
  import radio_ctrl_pkg::*;
#(
  parameter int unsigned CAL_CYCLES      = CAL_CYCLES_DEF,
  parameter int unsigned OSC_CYCLES      = OSC_CYCLES_DEF,
  parameter int unsigned FS_CYCLES       = FS_CYCLES_DEF,
  parameter int unsigned RX_SETTLE_SHIFT = 0
)
(
  input  wire logic                          i_clock,
  input  wire logic                          i_arst_n,
  input  wire logic [radio_ctrl_pkg::AW-1:0] i_addr,
  input  wire logic [radio_ctrl_pkg::DW-1:0] i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output logic      [radio_ctrl_pkg::DW-1:0] o_rdata,
  input  wire logic                          i_manual_reset,
  input  wire logic [7:0]                    i_temp,
  input  wire logic                          i_bit_valid,
  input  wire logic                          i_bit,
  input  wire logic [7:0]                    i_level_reading,
  input  wire logic                          i_sync_match,
  input  wire logic [radio_ctrl_pkg::DW-1:0] i_freq_offset,
  output logic                               o_osc_en,
  output logic                               o_synth_en,
  output logic                               o_synth_rx_freq,
  output logic                               o_tx_en,
  output logic                               o_rx_en,
  output logic                               o_cal_busy,
  output logic      [radio_ctrl_pkg::NFLAGS-1:0] o_flags,
  output logic      [radio_ctrl_pkg::DW-1:0] o_carrier_word
);
  import radio_ctrl_pkg::*;

  logic [2:0]    op_mode_q;
  logic          fsk_sel_q, ook_q;
  logic          det_en_q;
  logic [1:0]    len_sel_q;
  logic [4:0]    tol_q;
  logic          temp_dis_q, auto_cal_q, temp_flag_q;
  logic [1:0]    delta_sel_q;
  logic [7:0]    lim_q [3];
  logic [2:0]    trig_q;
  logic          afc_q;
  logic [DW-1:0] ramp_q, tbit_q, lvl_dly_q;
  logic [4:0]    rx_bandwidth_q, cbw_q;
  logic [7:0]    lvl_thr_q;
  logic [NFLAGS-1:0] flags_d;

  logic wr_cal, wr_flags, wr_carrier;
  assign wr_cal     = i_wr && i_addr == ADDR_CAL;
  assign wr_flags   = i_wr && i_addr == ADDR_FLAGS;
  assign wr_carrier = i_wr && i_addr == ADDR_CARRIER;

  // Configuration registers written by software
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      op_mode_q   <= RST_MODE;
      fsk_sel_q   <= 1'b1;
      ook_q       <= 1'b0;
      det_en_q    <= 1'b1;
      len_sel_q   <= RST_LEN;
      tol_q       <= RST_TOL;
      temp_dis_q  <= 1'b0;
      auto_cal_q  <= 1'b0;
      delta_sel_q <= 2'h0;
      lim_q       <= '{default: 8'h00};
      trig_q      <= TRIG_NONE;
      afc_q       <= 1'b0;
      ramp_q      <= RST_RAMP;
      rx_bandwidth_q      <= 5'h00;
      cbw_q       <= 5'h00;
      tbit_q      <= RST_TBIT;
      lvl_dly_q   <= RST_LDLY;
      lvl_thr_q   <= 8'h00;
    end
    else if (i_wr)
    begin
      unique case (i_addr)
        ADDR_MODE:
        begin
          op_mode_q <= i_wdata[MODE_LSB +: 3];
          fsk_sel_q <= i_wdata[FSK_BIT];
          ook_q     <= i_wdata[OOK_BIT];
        end
        ADDR_PREAMBLE:
        begin
          det_en_q  <= i_wdata[DET_BIT];
          len_sel_q <= i_wdata[LEN_LSB +: 2];
          tol_q     <= i_wdata[TOL_LSB +: 5];
        end
        ADDR_CAL:
        begin
          temp_dis_q  <= i_wdata[TEMP_DIS_BIT];
          auto_cal_q  <= i_wdata[AUTO_CAL_BIT];
          delta_sel_q <= i_wdata[DELTA_LSB +: 2];
        end
        ADDR_LVL_LIM: lim_q[0] <= i_wdata[7:0];
        ADDR_PRE_LIM: lim_q[1] <= i_wdata[7:0];
        ADDR_SYN_LIM: lim_q[2] <= i_wdata[7:0];
        ADDR_RXCFG:
        begin
          trig_q <= i_wdata[TRIG_LSB +: 3];
          afc_q  <= i_wdata[AFC_BIT];
        end
        ADDR_RAMP:    ramp_q    <= i_wdata;
        ADDR_BW:
        begin
          rx_bandwidth_q <= i_wdata[RX_BANDWIDTH_LSB +: 5];
          cbw_q  <= i_wdata[CBW_LSB +: 5];
        end
        ADDR_TBIT:    tbit_q    <= i_wdata;
        ADDR_LVL_DLY: lvl_dly_q <= i_wdata;
        ADDR_LVL_THR: lvl_thr_q <= i_wdata[7:0];
        default:      ;
      endcase
    end
  end

  // Mode sequencer
  logic [2:0]  act_mode_q;
  seq_state_t  seq_q;
  logic [CW-1:0] wait_q, tx_cyc, rx_cyc;
  logic        ready_q, rx_ready_q, lvl_ok_q, rx_entry_q, stage_rx_q;
  logic [DW-1:0] lvl_cnt_q;
  logic        need_synth, want_rx_freq;
  logic [4:0]  bw_idx;

  assign need_synth   = act_mode_q inside {MODE_SYNTH_TX, MODE_TX, MODE_SYNTH_RX, MODE_RX};
  assign want_rx_freq = act_mode_q inside {MODE_SYNTH_RX, MODE_RX};
  assign bw_idx       = afc_q ? cbw_q : rx_bandwidth_q;
  assign tx_cyc = CW'(TX_BASE_CYC) + (ook_q ? CW'(0) : CW'(ramp_q) * CW'(RAMP_CYC_PER_US))
                  + CW'(tbit_q >> 1);
  assign rx_cyc = CW'((RX_SETTLE_US[(bw_idx < N_BW) ? bw_idx : N_BW - 1] * CLK_MHZ)
                  >> RX_SETTLE_SHIFT);

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      act_mode_q      <= RST_MODE;
      seq_q           <= SQ_STEP;
      wait_q          <= '0;
      o_osc_en        <= 1'b0;
      o_synth_en      <= 1'b0;
      o_synth_rx_freq <= 1'b0;
      o_tx_en         <= 1'b0;
      o_rx_en         <= 1'b0;
      ready_q         <= 1'b0;
      rx_ready_q      <= 1'b0;
      rx_entry_q      <= 1'b0;
      stage_rx_q      <= 1'b0;
    end
    else
    begin
      rx_entry_q <= 1'b0;
      ready_q    <= 1'b0;
      rx_ready_q <= 1'b0;
      if (op_mode_q != act_mode_q)
      begin
        // Drop what the new mode does not use, then rebuild stage by stage
        act_mode_q <= op_mode_q;
        o_tx_en    <= 1'b0;
        o_rx_en    <= 1'b0;
        stage_rx_q <= 1'b0;
        if (!(op_mode_q inside {MODE_SYNTH_TX, MODE_TX, MODE_SYNTH_RX, MODE_RX}) ||
            (op_mode_q inside {MODE_SYNTH_RX, MODE_RX}) != o_synth_rx_freq)
          o_synth_en <= 1'b0;
        rx_entry_q <= op_mode_q == MODE_RX;
        seq_q      <= SQ_STEP;
      end
      else
      begin
        unique case (seq_q)
          SQ_STEP:
          begin
            seq_q <= SQ_WAIT;
            if (act_mode_q == MODE_SLEEP)
            begin
              o_osc_en <= 1'b0;
              seq_q    <= SQ_READY;
              ready_q  <= 1'b1;
            end
            else if (!o_osc_en)
            begin
              o_osc_en <= 1'b1;
              wait_q   <= CW'(OSC_CYCLES);
            end
            else if (need_synth && !o_synth_en)
            begin
              o_synth_en      <= 1'b1;
              o_synth_rx_freq <= want_rx_freq;
              wait_q          <= CW'(FS_CYCLES);
            end
            else if (act_mode_q == MODE_TX && !o_tx_en)
            begin
              o_tx_en <= 1'b1;
              wait_q  <= tx_cyc;
            end
            else if (act_mode_q == MODE_RX && !o_rx_en)
            begin
              o_rx_en    <= 1'b1;
              stage_rx_q <= 1'b1;
              wait_q     <= rx_cyc;
            end
            else
            begin
              seq_q   <= SQ_READY;
              ready_q <= 1'b1;
            end
          end
          SQ_WAIT:
          begin
            wait_q <= wait_q - CW'(1);
            if (wait_q <= CW'(1))
            begin
              seq_q      <= SQ_STEP;
              rx_ready_q <= stage_rx_q;
              stage_rx_q <= 1'b0;
            end
          end
          SQ_READY: ;
          default:  seq_q <= SQ_STEP;
        endcase
      end
    end
  end

  // Receiver usable, then first level sample after its own delay
  logic rx_live_q;
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rx_live_q <= 1'b0;
      lvl_ok_q  <= 1'b0;
      lvl_cnt_q <= '0;
    end
    else if (!o_rx_en || rx_entry_q)
    begin
      rx_live_q <= 1'b0;
      lvl_ok_q  <= 1'b0;
    end
    else if (rx_ready_q)
    begin
      rx_live_q <= 1'b1;
      lvl_cnt_q <= lvl_dly_q;
    end
    else if (rx_live_q && !lvl_ok_q)
    begin
      lvl_cnt_q <= lvl_cnt_q - DW'(1);
      lvl_ok_q  <= lvl_cnt_q <= DW'(1);
    end
  end

  // Carrier word, corrected once per receiver enable
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_carrier_word <= '0;
    else if (rx_ready_q && afc_q)
      o_carrier_word <= o_carrier_word - i_freq_offset;
    else if (wr_carrier)
      o_carrier_word <= i_wdata;
  end

  // Calibration and temperature watch
  logic [CW-1:0] cal_cnt_q;
  logic [7:0]    temp_ref_q;
  logic          ref_ok_q, beyond_q, beyond, temp_event, cal_start;
  logic [8:0]    tdiff, tabs;
  logic [8:0]    tthr;
  assign tdiff = {i_temp[7], i_temp} - {temp_ref_q[7], temp_ref_q};
  assign tabs  = tdiff[8] ? 9'(-tdiff) : tdiff;
  assign tthr  = 9'((delta_sel_q + 2'h0 + 1) * TEMP_STEP_C);
  assign beyond = !temp_dis_q && ref_ok_q && !o_cal_busy && tabs >= tthr;
  assign temp_event = beyond && !beyond_q;
  assign cal_start = i_manual_reset
                  || (wr_cal && i_wdata[CAL_TRIG_BIT] && fsk_sel_q
                      && act_mode_q == MODE_STANDBY)
                  || (temp_event && auto_cal_q);

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_cal_busy  <= 1'b1;
      cal_cnt_q   <= '0;
      temp_ref_q  <= 8'h00;
      ref_ok_q    <= 1'b0;
      beyond_q    <= 1'b0;
      temp_flag_q <= 1'b0;
    end
    else
    begin
      beyond_q <= beyond;
      temp_flag_q <= temp_event
                  || (temp_flag_q && !(wr_cal && i_wdata[TEMP_FLAG_BIT]));
      if (cal_start)
      begin
        o_cal_busy <= 1'b1;
        cal_cnt_q  <= '0;
      end
      else if (o_cal_busy)
      begin
        cal_cnt_q <= cal_cnt_q + CW'(1);
        if (cal_cnt_q + CW'(1) >= CW'(CAL_CYCLES))
        begin
          o_cal_busy <= 1'b0;
          temp_ref_q <= i_temp;
          ref_ok_q   <= 1'b1;
        end
      end
    end
  end

  // Preamble detector on alternating demodulated bits
  logic       prev_bit_q, pre_hit_q;
  logic [4:0] run_q, err_q, need;
  assign need = 5'((len_sel_q + 2'h0 + 1) * 8);
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      prev_bit_q <= 1'b0;
      run_q      <= '0;
      err_q      <= '0;
      pre_hit_q  <= 1'b0;
    end
    else
    begin
      pre_hit_q <= 1'b0;
      if (!det_en_q || !rx_live_q || len_sel_q == LEN_RSVD)
      begin
        run_q <= '0;
        err_q <= '0;
      end
      else if (i_bit_valid)
      begin
        prev_bit_q <= i_bit;
        if (i_bit != prev_bit_q)
        begin
          run_q <= run_q + 5'h01;
          if (run_q + 5'h01 >= need)
          begin
            pre_hit_q <= 1'b1;
            run_q   <= '0;
            err_q   <= '0;
          end
        end
        else if (err_q >= tol_q)
        begin
          run_q <= '0;
          err_q <= '0;
        end
        else
          err_q <= err_q + 5'h01;
      end
    end
  end

  // Bit period and 16-bit unit ticks while receiving
  logic [DW-1:0] bit_cnt_q;
  logic [3:0]    nib_q;
  logic          unit_tick_q;
  logic [2:0]    to_en, seen, expire;
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      bit_cnt_q <= '0;
      nib_q     <= 4'h0;
      unit_tick_q <= 1'b0;
    end
    else
    begin
      unit_tick_q <= 1'b0;
      if (rx_entry_q || act_mode_q != MODE_RX)
      begin
        bit_cnt_q <= '0;
        nib_q     <= 4'h0;
      end
      else if (bit_cnt_q + DW'(1) >= tbit_q)
      begin
        bit_cnt_q <= '0;
        nib_q     <= nib_q + 4'h1;
        unit_tick_q <= nib_q == 4'(BITS_PER_UNIT - 1);
      end
      else
        bit_cnt_q <= bit_cnt_q + DW'(1);
    end
  end

  always_comb
  begin
    unique case (trig_q)
      TRIG_LVL:  to_en = 3'b101;
      TRIG_PRE:  to_en = 3'b110;
      TRIG_BOTH: to_en = 3'b011;
      default:   to_en = 3'b000;
    endcase
  end
  assign seen = {i_sync_match, pre_hit_q, lvl_ok_q && i_level_reading > lvl_thr_q};

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_to
      wait_timer u_wait
      (
        .i_clock     (i_clock),
        .i_arst_n    (i_arst_n),
        .i_restart   (rx_entry_q),
        .i_unit_tick (unit_tick_q),
        .i_enable    (to_en[g]),
        .i_seen      (seen[g]),
        .i_limit     (lim_q[g]),
        .o_expire    (expire[g])
      );
    end
  endgenerate

  // Sticky flags: a set in the same cycle as a clear wins
  always_comb
  begin
    flags_d = o_flags & ~(wr_flags ? i_wdata[NFLAGS-1:0] : '0);
    flags_d[FL_PRE]          = flags_d[FL_PRE] | pre_hit_q;
    flags_d[FL_TO_LSB +: 3]  = flags_d[FL_TO_LSB +: 3] | expire;
    flags_d[FL_READY]        = flags_d[FL_READY] | ready_q;
    flags_d[FL_RXRDY]        = flags_d[FL_RXRDY] | rx_ready_q;
    flags_d[FL_LVLRDY]       = flags_d[FL_LVLRDY] | (lvl_ok_q && rx_live_q);
  end
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_flags <= '0;
    else
      o_flags <= flags_d;
  end

  // Read data one cycle after the read strobe, zero otherwise
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_rdata <= '0;
    else if (!i_rd)
      o_rdata <= '0;
    else
    begin
      unique case (i_addr)
        ADDR_MODE:     o_rdata <= DW'({ook_q, fsk_sel_q, op_mode_q});
        ADDR_PREAMBLE: o_rdata <= DW'({det_en_q, len_sel_q, tol_q});
        ADDR_CAL:      o_rdata <= DW'({temp_flag_q, delta_sel_q, auto_cal_q, temp_dis_q,
                                       o_cal_busy, 1'b0});
        ADDR_LVL_LIM:  o_rdata <= DW'(lim_q[0]);
        ADDR_PRE_LIM:  o_rdata <= DW'(lim_q[1]);
        ADDR_SYN_LIM:  o_rdata <= DW'(lim_q[2]);
        ADDR_RXCFG:    o_rdata <= DW'({afc_q, trig_q});
        ADDR_RAMP:     o_rdata <= ramp_q;
        ADDR_BW:       o_rdata <= {3'h0, cbw_q, 3'h0, rx_bandwidth_q};
        ADDR_FLAGS:    o_rdata <= DW'(o_flags);
        ADDR_TBIT:     o_rdata <= tbit_q;
        ADDR_CARRIER:  o_rdata <= o_carrier_word;
        ADDR_LVL_DLY:  o_rdata <= lvl_dly_q;
        ADDR_LVL_THR:  o_rdata <= DW'(lvl_thr_q);
        default:       o_rdata <= '0;
      endcase
    end
  end
endmodule

/* File: testbench/bit_source.sv */
// Demodulated bit stream model standing in for the receive chain
`timescale 1ns/1ps
module bit_source
(
  input  wire logic        i_clock,
  input  wire logic        i_arst_n,
  input  wire logic        i_enable,
  input  wire logic [15:0] i_period,
  output logic             o_bit_valid,
  output logic             o_bit
);
  logic [15:0] cnt_q;
  logic        pat_q;
  // Between valid pulses the line wanders so stale bits are never reused
  assign o_bit = o_bit_valid ? pat_q : cnt_q[0];
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cnt_q       <= '0;
      pat_q       <= 1'b0;
      o_bit_valid <= 1'b0;
    end
    else
    begin
      cnt_q       <= (cnt_q + 16'h1 >= i_period) ? '0 : cnt_q + 16'h1;
      o_bit_valid <= i_enable && cnt_q == '0;
      if (i_enable && cnt_q == '0)
        pat_q <= ~pat_q;
    end
  end
endmodule

/* File: testbench/radio_ctrl_assertions.sv */
// Port-level assertions of the radio controller
`timescale 1ns/1ps
module radio_ctrl_assertions
  import radio_ctrl_pkg::*;
(
  input wire logic                              i_clock,
  input wire logic                              i_arst_n,
  input wire logic                              i_manual_reset,
  input wire logic                              o_osc_en,
  input wire logic                              o_synth_en,
  input wire logic                              o_tx_en,
  input wire logic                              o_rx_en,
  input wire logic                              o_cal_busy,
  input wire logic [radio_ctrl_pkg::NFLAGS-1:0] o_flags
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  AST_TX_RX_EXCL: assert property (!(o_tx_en && o_rx_en))
    else $error("tx and rx both on");
  AST_RX_NEEDS_SYNTH: assert property (o_rx_en |-> o_synth_en && o_osc_en)
    else $error("rx without synth");
  AST_SYNTH_AFTER_OSC: assert property ($rose(o_synth_en) |-> $past(o_osc_en))
    else $error("synth before osc");
  AST_PATH_AFTER_SYNTH: assert property ($rose(o_rx_en || o_tx_en) |-> $past(o_synth_en))
    else $error("path before synth");
  AST_MANUAL_CAL: assert property (i_manual_reset |-> ##[1:2] o_cal_busy)
    else $error("no cal after manual reset");
  AST_CAL_HOLDS: assert property ($rose(o_cal_busy) |=> o_cal_busy [*8])
    else $error("cal too short");
  AST_RXRDY_SETTLED: assert property ($rose(o_flags[FL_RXRDY]) |-> $past(o_rx_en, 8))
    else $error("rx ready too early");
  AST_RXRDY_IN_RX: assert property ($rose(o_flags[FL_RXRDY]) |-> o_rx_en)
    else $error("rx ready outside rx");
  AST_LVL_AFTER_RDY: assert property ($rose(o_flags[FL_LVLRDY]) |-> o_flags[FL_RXRDY])
    else $error("level before rx ready");
  cover property ($rose(o_flags[FL_RXRDY]));
  cover property ($rose(o_flags[FL_PRE]));
  cover property ($fell(o_cal_busy));
endmodule
bind radio_ctrl radio_ctrl_assertions u_chk (.i_clock(i_clock), .i_arst_n(i_arst_n),
  .i_manual_reset(i_manual_reset), .o_osc_en(o_osc_en), .o_synth_en(o_synth_en),
  .o_tx_en(o_tx_en), .o_rx_en(o_rx_en), .o_cal_busy(o_cal_busy), .o_flags(o_flags));

/* File: testbench/test_radio_ctrl.sv */
// Self-checking bench of the radio controller
`timescale 1ns/1ps
module test_radio_ctrl;
  import radio_ctrl_pkg::*;
  logic              i_clock = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic              i_manual_reset = 1'b0, i_sync_match = 1'b0, src_en = 1'b0;
  logic [AW-1:0]     i_addr = '0;
  logic [DW-1:0]     i_wdata = '0, i_freq_offset = '0, o_rdata, o_carrier_word, car;
  logic [7:0]        i_temp = 8'h19, i_level_reading = 8'h00;
  logic              i_bit_valid, i_bit, o_osc_en, o_synth_en, o_synth_rx_freq;
  logic              o_tx_en, o_rx_en, o_cal_busy;
  logic [NFLAGS-1:0] o_flags;
  logic [2:0]        trig [4] = '{3'b000, 3'b001, 3'b110, 3'b111};
  logic [31:0]       seed = 32'hb7eda4dc;
  int                num_errors = 0, checked = 0;
  always #12.5 i_clock = ~i_clock;
  radio_ctrl #(.CAL_CYCLES(50), .OSC_CYCLES(20), .FS_CYCLES(10), .RX_SETTLE_SHIFT(6)) dut (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_manual_reset(i_manual_reset), .i_temp(i_temp),
    .i_bit_valid(i_bit_valid), .i_bit(i_bit), .i_level_reading(i_level_reading),
    .i_sync_match(i_sync_match), .i_freq_offset(i_freq_offset), .o_osc_en(o_osc_en),
    .o_synth_en(o_synth_en), .o_synth_rx_freq(o_synth_rx_freq), .o_tx_en(o_tx_en),
    .o_rx_en(o_rx_en), .o_cal_busy(o_cal_busy), .o_flags(o_flags),
    .o_carrier_word(o_carrier_word));
  bit_source src (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_enable(src_en),
    .i_period(16'h0004), .o_bit_valid(i_bit_valid), .o_bit(i_bit));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Expected timeout flags {sync, preamble, level} for a start event code
  function automatic logic [2:0] exp_to(input logic [2:0] t);
    return (t == 3'b001) ? 3'b101 : (t == 3'b110) ? 3'b110 : (t == 3'b111) ? 3'b011 : 3'b000;
  endfunction
  task automatic chk(input string n, input logic [DW-1:0] s, input logic [DW-1:0] e);
    checked++;
    if (s !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      num_errors++;
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rdchk(input string n, input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 chk(n, o_rdata, e);
  endtask
  task automatic wait_cal(input logic v);
    for (int i = 0; i < 200 && o_cal_busy !== v; i++)
      @(posedge i_clock);
    #1 chk("cal_busy", {15'h0, o_cal_busy}, {15'h0, v});
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge i_clock);
    chk("cal_busy_rst", {15'h0, o_cal_busy}, 16'h0001);
    i_arst_n <= 1'b1;
    wait_cal(1'b0);
    rdchk("preamble", ADDR_PREAMBLE, 16'h00aa);
    rdchk("tbit", ADDR_TBIT, RST_TBIT);
    rdchk("ramp", ADDR_RAMP, RST_RAMP);
    rdchk("unmapped", 4'hf, 16'h0000);
    wr(ADDR_PREAMBLE, 16'h00aa);
    wr(ADDR_TBIT, 16'h0004);
    wr(ADDR_BW, 16'h1414);
    wr(ADDR_LVL_THR, 16'h00ff);
    wr(ADDR_LVL_LIM, 16'h0002);
    wr(ADDR_PRE_LIM, 16'h0002);
    wr(ADDR_SYN_LIM, 16'h0002);
    wr(ADDR_MODE, 16'h0009);
    wr(ADDR_CAL, 16'h0001);
    wait_cal(1'b1);
    wait_cal(1'b0);
    @(posedge i_clock);
    i_manual_reset <= 1'b1;
    @(posedge i_clock);
    i_manual_reset <= 1'b0;
    wait_cal(1'b1);
    wait_cal(1'b0);
    for (int k = 0; k < 5; k++)
    begin
      seed = lfsr(seed);
      car = seed[15:0];
      wr(ADDR_MODE, 16'h0009);
      i_freq_offset <= seed[31:16];
      src_en <= (k == 4);
      wr(ADDR_FLAGS, 16'h007f);
      wr(ADDR_CARRIER, car);
      wr(ADDR_PRE_LIM, (k == 4) ? 16'h0010 : 16'h0002);
      wr(ADDR_RXCFG, (k == 4) ? 16'h0006 : {12'h0, k == 0, trig[k]});
      wr(ADDR_MODE, 16'h000d);
      repeat (400) @(posedge i_clock);
      #1 chk("rx_ready", {13'h0, o_synth_rx_freq, o_flags[6:5]}, 16'h0007);
      if (k < 4)
        chk("timeouts", {13'h0, o_flags[3:1]}, {13'h0, exp_to(trig[k])});
      if (k == 0)
        chk("carrier", o_carrier_word, car - seed[31:16]);
    end
    chk("pre_found", {15'h0, o_flags[FL_PRE]}, 16'h0001);
    chk("pre_timeout", {15'h0, o_flags[2]}, 16'h0000);
    chk("sync_timeout", {15'h0, o_flags[3]}, 16'h0001);
    wr(ADDR_CAL, 16'h0008);
    i_temp <= 8'h1e;
    wait_cal(1'b1);
    wait_cal(1'b0);
    rdchk("temp_flag", ADDR_CAL, 16'h0048);
    wr(ADDR_RAMP, 16'h0001);
    wr(ADDR_MODE, 16'h000b);
    wr(ADDR_FLAGS, 16'h007f);
    repeat (240) @(posedge i_clock);
    #1 chk("tx_start", {13'h0, o_synth_rx_freq, o_tx_en, o_flags[4]}, 16'h0002);
    repeat (60) @(posedge i_clock);
    #1 chk("tx_ready", {14'h0, o_tx_en, o_flags[4]}, 16'h0003);
    wr(ADDR_MODE, 16'h0008);
    wr(ADDR_CAL, 16'h0001);
    repeat (5) @(posedge i_clock);
    #1 chk("cal_refused", {14'h0, o_osc_en, o_cal_busy}, 16'h0000);
    end_of_test();
  end
  initial
  begin
    repeat (20000) @(posedge i_clock);
    num_errors++;
    end_of_test();
  end
endmodule
